// >>> tmr8_timer.v
// Purpose: 8-bit timer with compare outputs, normal, clear-on-match, fast pwm
// Assumes: classic wishbone master on clk_i, 40 MHz
// Notes: phase correct and reserved waveform codes freeze the counter
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "tmr8_regs.vh"

module tmr8_timer (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // compare output pins, a in bit 0, b in bit 1
  output wire [1:0] oc_pin_o,
  output wire [1:0] oc_pin_oe_n_o
);

  // control registers
  reg [2:0] waveform_select_r;
  reg [2:0] clock_select_r;
  reg [1:0] output_action_select_a_r;
  reg [1:0] output_action_select_b_r;
  reg [1:0] port_val_r;
  reg [1:0] pin_direction_bit_r;

  // counter, flags and strobes
  reg [7:0] count_value_r;
  reg [7:0] count_value_nxt;
  reg overflow_flag_r;
  reg [1:0] match_flag_r;
  reg [1:0] force_match_strobe_r;
  reg match_block_r;
  reg [9:0] pre_r;

  // per channel compare storage
  reg [7:0] cmp_buf_r [0:1];
  reg [7:0] compare_value_r [0:1];

  // bus decode
  wire bus_req;
  wire bus_wr;
  wire bus_rd;
  wire wr_ctrl;
  wire wr_count;
  wire wr_flags;
  wire wr_force;
  wire wr_port;
  wire [1:0] wr_cmp;

  // mode and event wires
  wire mode_norm;
  wire mode_clr;
  wire mode_fast;
  wire mode_ok;
  wire [7:0] top_val;
  wire at_top;
  wire tick;
  wire run;
  wire [1:0] hit;
  wire wrap;
  wire ovf_set;
  wire [1:0] compare_output_state;
  reg [9:0] div_mask;
  reg [31:0] rd_data;

  // a request is taken in the cycle before ack rises
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;
  assign wr_ctrl = bus_wr & (wb_adr_i == `TMR8_ADR_CTRL);
  assign wr_count = bus_wr & (wb_adr_i == `TMR8_ADR_COUNT) & wb_sel_i[0];
  assign wr_flags = bus_wr & (wb_adr_i == `TMR8_ADR_FLAGS) & wb_sel_i[0];
  assign wr_force = bus_wr & (wb_adr_i == `TMR8_ADR_FORCE) & wb_sel_i[0];
  assign wr_port = bus_wr & (wb_adr_i == `TMR8_ADR_PORT) & wb_sel_i[0];
  assign wr_cmp[0] = bus_wr & (wb_adr_i == `TMR8_ADR_CMPA) & wb_sel_i[0];
  assign wr_cmp[1] = bus_wr & (wb_adr_i == `TMR8_ADR_CMPB) & wb_sel_i[0];

  // waveform select decode; only these codes drive the counter
  assign mode_norm = (waveform_select_r == `TMR8_WGM_NORMAL);
  assign mode_clr = (waveform_select_r == `TMR8_WGM_CLRMATCH);
  assign mode_fast = (waveform_select_r == `TMR8_WGM_FAST_MAX) ||
                     (waveform_select_r == `TMR8_WGM_FAST_CMPA);
  assign mode_ok = mode_norm | mode_clr | mode_fast;

  // top of the fast pwm sequence
  assign top_val = (waveform_select_r == `TMR8_WGM_FAST_CMPA) ?
                   compare_value_r[0] : `TMR8_MAX;
  assign at_top = (count_value_r == top_val);

  // prescaler mask from the clock select field
  always @* begin
    case (clock_select_r)
      3'h2: div_mask = `TMR8_DIV8;
      3'h3: div_mask = `TMR8_DIV32;
      3'h4: div_mask = `TMR8_DIV64;
      3'h5: div_mask = `TMR8_DIV128;
      3'h6: div_mask = `TMR8_DIV256;
      3'h7: div_mask = `TMR8_DIV1024;
      default: div_mask = 10'h000;
    endcase
  end

  // timer clock enable: one clk_i pulse per divided period
  assign tick = (clock_select_r != `TMR8_RST_CS) && ((pre_r & div_mask) == div_mask);
  assign run = tick & mode_ok & ~wr_count;

  // prescaler counter, cleared to zero while stopped
  always @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= 10'h000;
    end else if (clock_select_r == `TMR8_RST_CS) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // wrap from top to bottom in fast pwm
  assign wrap = run & mode_fast & at_top;

  // overflow events per mode
  assign ovf_set = run & (((mode_norm | mode_clr) & (count_value_r == `TMR8_MAX)) |
                          (mode_fast & at_top));

  // counter next value; cpu write overrides counting
  always @* begin
    count_value_nxt = count_value_r;
    if (wr_count) begin
      count_value_nxt = wb_dat_i[7:0];
    end else if (run) begin
      if (mode_clr && hit[0]) begin
        count_value_nxt = `TMR8_BOTTOM;
      end else if (mode_fast && at_top) begin
        count_value_nxt = `TMR8_BOTTOM;
      end else begin
        count_value_nxt = count_value_r + 8'h01;
      end
    end
  end

  // counter register and match block after a count write
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_value_r <= `TMR8_RST_BYTE;
      match_block_r <= 1'b0;
    end else begin
      count_value_r <= count_value_nxt;
      if (wr_count) begin
        match_block_r <= 1'b1;
      end else if (tick) begin
        match_block_r <= 1'b0;
      end
    end
  end

  // control, port and direction registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      waveform_select_r <= `TMR8_RST_WGM;
      clock_select_r <= `TMR8_RST_CS;
      output_action_select_a_r <= `TMR8_RST_ACT;
      output_action_select_b_r <= `TMR8_RST_ACT;
      port_val_r <= 2'h0;
      pin_direction_bit_r <= 2'h0;
    end else begin
      if (wr_ctrl && wb_sel_i[0]) begin
        waveform_select_r <= wb_dat_i[`TMR8_WGM_LSB +: 3];
        clock_select_r <= wb_dat_i[`TMR8_CS_LSB +: 3];
      end
      if (wr_ctrl && wb_sel_i[1]) begin
        output_action_select_a_r <= wb_dat_i[`TMR8_COMA_LSB +: 2];
        output_action_select_b_r <= wb_dat_i[`TMR8_COMB_LSB +: 2];
      end
      if (wr_port) begin
        port_val_r <= {wb_dat_i[2], wb_dat_i[0]};
        pin_direction_bit_r <= {wb_dat_i[3], wb_dat_i[1]};
      end
    end
  end

  // overflow flag: hardware only sets, software writes one to clear, set wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_r <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag_r <= 1'b1;
    end else if (wr_flags && wb_dat_i[`TMR8_FLG_OVF]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // force strobe lasts one cycle and acts only outside pwm
  always @(posedge clk_i) begin
    if (rst_i) begin
      force_match_strobe_r <= 2'h0;
    end else if (wr_force && !mode_fast) begin
      force_match_strobe_r <= wb_dat_i[1:0];
    end else begin
      force_match_strobe_r <= 2'h0;
    end
  end

  // per channel compare, match flag and output stage
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
      wire [1:0] act;
      assign act = (gi == 0) ? output_action_select_a_r : output_action_select_b_r;

      // comparator, gated by the timer tick and the write block
      assign hit[gi] = run & ~match_block_r & (count_value_r == compare_value_r[gi]);

      // compare value: buffered in pwm, direct otherwise
      always @(posedge clk_i) begin
        if (rst_i) begin
          cmp_buf_r[gi] <= `TMR8_RST_BYTE;
          compare_value_r[gi] <= `TMR8_RST_BYTE;
        end else begin
          if (wr_cmp[gi]) begin
            cmp_buf_r[gi] <= wb_dat_i[7:0];
          end
          if (wr_cmp[gi] && !mode_fast) begin
            compare_value_r[gi] <= wb_dat_i[7:0];
          end else if (wrap) begin
            compare_value_r[gi] <= cmp_buf_r[gi];
          end
        end
      end

      // match flag, set wins over the write-one clear
      always @(posedge clk_i) begin
        if (rst_i) begin
          match_flag_r[gi] <= 1'b0;
        end else if (hit[gi]) begin
          match_flag_r[gi] <= 1'b1;
        end else if (wr_flags && wb_dat_i[`TMR8_FLG_MATA + gi]) begin
          match_flag_r[gi] <= 1'b0;
        end
      end

      // output state and pin override
      tmr8_oc_chan u_oc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hit_i(hit[gi]),
        .wrap_i(wrap),
        .force_i(force_match_strobe_r[gi]),
        .pwm_i(mode_fast),
        .act_i(act),
        .port_val_i(port_val_r[gi]),
        .dir_out_i(pin_direction_bit_r[gi]),
        .state_o(compare_output_state[gi]),
        .pin_o(oc_pin_o[gi]),
        .pin_oe_n_o(oc_pin_oe_n_o[gi])
      );
    end
  endgenerate

  // read multiplexer, unmapped offsets read zero
  always @* begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `TMR8_ADR_CTRL: begin
        rd_data[`TMR8_WGM_LSB +: 3] = waveform_select_r;
        rd_data[`TMR8_CS_LSB +: 3] = clock_select_r;
        rd_data[`TMR8_COMA_LSB +: 2] = output_action_select_a_r;
        rd_data[`TMR8_COMB_LSB +: 2] = output_action_select_b_r;
      end
      `TMR8_ADR_COUNT: rd_data[7:0] = count_value_r;
      `TMR8_ADR_CMPA: rd_data[7:0] = cmp_buf_r[0];
      `TMR8_ADR_CMPB: rd_data[7:0] = cmp_buf_r[1];
      `TMR8_ADR_FLAGS: rd_data[2:0] = {match_flag_r, overflow_flag_r};
      `TMR8_ADR_PORT: begin
        rd_data[3:0] = {pin_direction_bit_r[1], port_val_r[1],
                        pin_direction_bit_r[0], port_val_r[0]};
        rd_data[5:4] = compare_output_state;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // one-cycle ack, read data registered with it
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // tmr8_timer

// >>> tmr8_regs.vh
// Purpose: constants for the 8-bit timer compare and waveform block
// Assumes: classic wishbone, 8-bit byte address, 32-bit data words
// Notes: offsets, field positions, reset values and divider masks
//
// Function
// - nonzero action field routes state to pin
// - state reaches pin only when direction outputs
// - pin override ignores the waveform select
// - compare state is its own flip-flop
// - action zero leaves state untouched at matches
// - new action applies from next match on
// - force strobe applies action at once, non-pwm
// - count sequence follows waveform select only
// - mode zero counts up, wraps ff to 00
// - overflow set as count becomes zero
// - count value writable at any time
// - mode two clears counter on match a
// - mode two sets match flag a at top
// - clear-on-match compare a unbuffered, may miss
// - action one toggles channel a per match
// - clear-on-match overflow on max to zero
// - modes three and seven count single slope
// - fast pwm clears the count after top
// - fast pwm sets overflow at top
// - actions two/three clear/set at match, reverse
// - bottom compare spikes, max compare holds level
// - fast pwm action one toggles, buffered compare
// - equal count sets match flag next tick
// - pwm compare writes buffered, loaded at top
// - clock select zero stops; cpu write wins
`ifndef TMR8_REGS_VH
`define TMR8_REGS_VH

// register byte offsets
`define TMR8_ADR_CTRL 8'h00
`define TMR8_ADR_COUNT 8'h04
`define TMR8_ADR_CMPA 8'h08
`define TMR8_ADR_CMPB 8'h0c
`define TMR8_ADR_FLAGS 8'h10
`define TMR8_ADR_FORCE 8'h14
`define TMR8_ADR_PORT 8'h18

// control field positions
`define TMR8_WGM_LSB 0
`define TMR8_CS_LSB 4
`define TMR8_COMA_LSB 8
`define TMR8_COMB_LSB 10

// flag bit positions
`define TMR8_FLG_OVF 0
`define TMR8_FLG_MATA 1
`define TMR8_FLG_MATB 2

// waveform select codes
`define TMR8_WGM_NORMAL 3'h0
`define TMR8_WGM_CLRMATCH 3'h2
`define TMR8_WGM_FAST_MAX 3'h3
`define TMR8_WGM_FAST_CMPA 3'h7

// output action codes
`define TMR8_ACT_NONE 2'h0
`define TMR8_ACT_TOGGLE 2'h1
`define TMR8_ACT_CLEAR 2'h2
`define TMR8_ACT_SET 2'h3

// count extremes
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00

// prescaler masks, tick when masked bits all ones
`define TMR8_DIV8 10'h007
`define TMR8_DIV32 10'h01f
`define TMR8_DIV64 10'h03f
`define TMR8_DIV128 10'h07f
`define TMR8_DIV256 10'h0ff
`define TMR8_DIV1024 10'h3ff

// reset values
`define TMR8_RST_BYTE 8'h00
`define TMR8_RST_ACT 2'h0
`define TMR8_RST_WGM 3'h0
`define TMR8_RST_CS 3'h0

`endif

// >>> tmr8_oc_chan.v
// Purpose: one compare output channel: state flip-flop and pin override
// Assumes: hit, wrap and force are single clk_i pulses
// Notes: pin outputs are registered
`timescale 1ns/1ps
`include "tmr8_regs.vh"

module tmr8_oc_chan (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // events from the counter
  input wire hit_i,
  input wire wrap_i,
  input wire force_i,
  input wire pwm_i,
  // configuration
  input wire [1:0] act_i,
  input wire port_val_i,
  input wire dir_out_i,
  // state and pin
  output reg state_o,
  output reg pin_o,
  output reg pin_oe_n_o
);

  reg state_nxt;

  // waveform generator: next compare output state
  always @* begin
    state_nxt = state_o;
    if (pwm_i) begin
      if (wrap_i) begin
        // top to bottom: restore level, wins over a same-tick match
        if (act_i == `TMR8_ACT_CLEAR) begin
          state_nxt = 1'b1;
        end else if (act_i == `TMR8_ACT_SET) begin
          state_nxt = 1'b0;
        end
      end
      if (hit_i && !(wrap_i && act_i[1])) begin
        case (act_i)
          `TMR8_ACT_TOGGLE: state_nxt = ~state_o;
          `TMR8_ACT_CLEAR: state_nxt = 1'b0;
          `TMR8_ACT_SET: state_nxt = 1'b1;
          default: state_nxt = state_o;
        endcase
      end
    end else if (hit_i || force_i) begin
      case (act_i)
        `TMR8_ACT_TOGGLE: state_nxt = ~state_o;
        `TMR8_ACT_CLEAR: state_nxt = 1'b0;
        `TMR8_ACT_SET: state_nxt = 1'b1;
        default: state_nxt = state_o;
      endcase
    end
  end

  // state flip-flop separate from the pin, plus pin mux
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_o <= 1'b0;
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      state_o <= state_nxt;
      pin_o <= (act_i != `TMR8_ACT_NONE) ? state_o : port_val_i;
      pin_oe_n_o <= ~dir_out_i;
    end
  end

endmodule // tmr8_oc_chan

// >>> tmr8_timer_asserts.sv
// Purpose: port checks for the 8-bit timer compare block
// Assumes: classic wishbone on clk_i, synchronous reset
// Notes: helper regs mirror control fields written over the bus
`timescale 1ns/1ps
`include "tmr8_regs.vh"
module tmr8_timer_asserts (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave side
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // compare pins
  input wire [1:0] oc_pin_o,
  input wire [1:0] oc_pin_oe_n_o
);
  reg [1:0] act_r;
  reg [2:0] wgm_r;
  reg [2:0] cs_r;
  reg [3:0] port_r;
  reg [7:0] cnt_r;
  reg hold_r;
  reg [1:0] quiet_r;
  // a request is taken while no ack is out
  wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = tk & wb_we_i & wb_sel_i[0];
  wire wr_ctl = tk & wb_we_i & wb_adr_i == `TMR8_ADR_CTRL;
  wire wr_port = wr & wb_adr_i == `TMR8_ADR_PORT;
  wire frc = wr & wb_adr_i == `TMR8_ADR_FORCE & wb_dat_i[0] & wgm_r == `TMR8_WGM_NORMAL;
  // mirror of written fields; quiet counts cycles since a pin-relevant write
  always @(posedge clk_i) begin
    if (rst_i) begin
      act_r <= 2'h0;
      wgm_r <= 3'h0;
      cs_r <= 3'h0;
      port_r <= 4'h0;
      cnt_r <= 8'h00;
      hold_r <= 1'b1;
      quiet_r <= 2'h3;
    end else begin
      quiet_r <= (wr_port | wr_ctl) ? 2'h0 : (quiet_r == 2'h3 ? quiet_r : quiet_r + 2'h1);
      if (wr_ctl & wb_sel_i[1]) act_r <= wb_dat_i[9:8];
      if (wr_ctl & wb_sel_i[0]) begin
        wgm_r <= wb_dat_i[2:0];
        cs_r <= wb_dat_i[6:4];
        if (wb_dat_i[6:4] != 3'h0) hold_r <= 1'b0;
      end
      if (wr_port) port_r <= wb_dat_i[3:0];
      if (wr & wb_adr_i == `TMR8_ADR_COUNT) begin
        cnt_r <= wb_dat_i[7:0];
        hold_r <= (cs_r == 3'h0);
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_follows_a: assert property (tk |=> wb_ack_o) else $error("request not acked next cycle");
  reset_idle_a: assert property ($fell(rst_i) |-> !wb_ack_o && oc_pin_o == 2'b00 &&
    oc_pin_oe_n_o == 2'b11) else $error("pins not idle after reset");
  pin_source_a: assert property (quiet_r == 2'h3 && act_r == 2'h0 |->
    oc_pin_o[0] == port_r[0]) else $error("pin a not from port value");
  pin_dir_a: assert property (quiet_r == 2'h3 |->
    oc_pin_oe_n_o == ~{port_r[3], port_r[1]}) else $error("pin enable wrong");
  force_set_a: assert property (frc && act_r == `TMR8_ACT_SET |-> ##[1:5] oc_pin_o[0])
    else $error("force set missing");
  force_clr_a: assert property (frc && act_r == `TMR8_ACT_CLEAR |-> ##[1:5] !oc_pin_o[0])
    else $error("force clear missing");
  count_hold_a: assert property (tk && !wb_we_i && wb_adr_i == `TMR8_ADR_COUNT && hold_r
    |=> wb_dat_o[7:0] == cnt_r) else $error("stopped count changed");
endmodule // tmr8_timer_asserts

bind tmr8_timer tmr8_timer_asserts i_tmr8_timer_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .oc_pin_o(oc_pin_o), .oc_pin_oe_n_o(oc_pin_oe_n_o));

// >>> tmr8_pin_load.sv
// Purpose: external load on one compare output pin
// Assumes: no pull resistor on the line
// Notes: a released line shows a changing pattern, never a stale level
`timescale 1ns/1ps
module tmr8_pin_load (
  // clock
  input wire clk_i,
  // pin from the device
  input wire pin_i,
  input wire oe_n_i,
  // level seen by the load
  output reg line_o
);
  reg flip_r = 1'b0;
  // pattern source for the floating line
  always @(posedge clk_i) begin
    flip_r <= ~flip_r;
  end
  // driven level, or the pattern while released
  always @* begin
    line_o = oe_n_i ? flip_r : pin_i;
  end
endmodule // tmr8_pin_load

// >>> timer8_compare_waveform_modes_tb_top.sv
// Purpose: self-checking bench for the 8-bit timer compare block
// Assumes: 40 MHz clock, classic wishbone master
// Notes: pwm duty is measured as high cycles over whole periods
`timescale 1ns/1ps
`include "tmr8_regs.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", n, e, s); end end
module timer8_compare_waveform_modes_tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [1:0] oc_pin_o;
  wire [1:0] oc_pin_oe_n_o;
  wire [1:0] line;
  integer mismatches = 0;
  integer checked = 0;
  integer i, hi, n, m;
  reg [31:0] rd;
  reg [7:0] c;
  reg [1:0] act;
  reg st;
  reg [9:0] acts = {2'h0, 2'h1, 2'h1, 2'h3, 2'h2};
  // clock
  always #12.5 clk_i = ~clk_i;
  tmr8_timer i_tmr8_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .oc_pin_o(oc_pin_o),
    .oc_pin_oe_n_o(oc_pin_oe_n_o));
  tmr8_pin_load i_load_a (.clk_i(clk_i), .pin_i(oc_pin_o[0]), .oe_n_i(oc_pin_oe_n_o[0]),
    .line_o(line[0]));
  tmr8_pin_load i_load_b (.clk_i(clk_i), .pin_i(oc_pin_o[1]), .oe_n_i(oc_pin_oe_n_o[1]),
    .line_o(line[1]));
  // one classic cycle; held until ack is sampled high
  task wb_xfer(input reg we, input reg [7:0] adr, input reg [31:0] dat);
    integer t;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      t = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && t < 20) begin
        t++;
        @(posedge clk_i);
      end
      if (t == 20) mismatches++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  // high cycles of a pin line over a window
  task meas(input integer ch, input integer win);
    begin
      hi = 0;
      repeat (win) begin
        @(negedge clk_i);
        hi = hi + line[ch];
      end
    end
  endtask
  // compare state after an action is applied
  function reg act_next(input reg [1:0] a, input reg s);
    act_next = (a == 2'h3) ? 1'b1 : (a == 2'h2) ? 1'b0 : (a == 2'h1) ? ~s : s;
  endfunction
  // high cycles per 256-tick fast pwm period
  function integer pwm_hi(input reg [1:0] a, input reg [7:0] cv);
    pwm_hi = (a == 2'h2) ? cv + 1 : 255 - cv;
  endfunction
  // verdict and end of run
  task stop_test;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #(25 * 40000);
    mismatches++;
    stop_test;
  end
  initial begin
    void'($urandom(32'hdb7f));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 32; i += 4) begin
      wb_xfer(0, i[7:0], 32'h0);
      `CHK("reset reg", 32'h0, rd);
    end
    `CHK("oe_n", 2'b11, oc_pin_oe_n_o);
    c = $urandom;
    wb_xfer(1, `TMR8_ADR_COUNT, {24'h0, c});
    repeat (10) @(posedge clk_i);
    wb_xfer(0, `TMR8_ADR_COUNT, 32'h0);
    `CHK("count", c, rd[7:0]);
    st = 1'b0;
    for (i = 0; i < 5; i++) begin
      act = acts[2*i +: 2];
      wb_xfer(1, `TMR8_ADR_CTRL, {22'h0, act, 8'h00});
      wb_xfer(1, `TMR8_ADR_FORCE, 32'h1);
      st = act_next(act, st);
      wb_xfer(0, `TMR8_ADR_PORT, 32'h0);
      `CHK("state a", st, rd[4]);
    end
    wb_xfer(1, `TMR8_ADR_PORT, 32'h2);
    repeat (3) @(posedge clk_i);
    `CHK("pin port", 1'b0, line[0]);
    wb_xfer(1, `TMR8_ADR_CTRL, 32'h100);
    repeat (3) @(posedge clk_i);
    `CHK("pin state", st, line[0]);
    wb_xfer(1, `TMR8_ADR_COUNT, 32'hfa);
    wb_xfer(1, `TMR8_ADR_FLAGS, 32'h7);
    wb_xfer(1, `TMR8_ADR_CTRL, 32'h10);
    repeat (20) @(posedge clk_i);
    wb_xfer(1, `TMR8_ADR_CTRL, 32'h0);
    wb_xfer(0, `TMR8_ADR_COUNT, 32'h0);
    `CHK("wrapped", 1'b1, rd[7:0] < 8'h20);
    wb_xfer(0, `TMR8_ADR_FLAGS, 32'h0);
    `CHK("overflow", 1'b1, rd[0]);
    n = 4 + $urandom % 20;
    wb_xfer(1, `TMR8_ADR_CMPA, n);
    wb_xfer(1, `TMR8_ADR_COUNT, 32'h0);
    wb_xfer(1, `TMR8_ADR_CTRL, 32'h112);
    repeat (100) @(posedge clk_i);
    meas(0, 8 * (n + 1));
    `CHK("ctc high", 4 * (n + 1), hi);
    wb_xfer(1, `TMR8_ADR_FLAGS, 32'h7);
    repeat (300) @(posedge clk_i);
    wb_xfer(0, `TMR8_ADR_FLAGS, 32'h0);
    `CHK("ctc flags", 3'b110, rd[2:0]);
    wb_xfer(1, `TMR8_ADR_COUNT, 32'hf0);
    repeat (40) @(posedge clk_i);
    wb_xfer(0, `TMR8_ADR_FLAGS, 32'h0);
    `CHK("missed top", 1'b1, rd[0]);
    for (i = 0; i < 6; i++) begin
      c = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'hff : $urandom;
      act = (i < 3) ? 2'h2 : 2'h3;
      wb_xfer(1, `TMR8_ADR_CMPA, {24'h0, c});
      wb_xfer(1, `TMR8_ADR_CTRL, {22'h0, act, 8'h13});
      repeat (600) @(posedge clk_i);
      meas(0, 256);
      `CHK("pwm high", pwm_hi(act, c), hi);
    end
    n = 20 + $urandom % 60;
    wb_xfer(1, `TMR8_ADR_CMPA, n);
    wb_xfer(1, `TMR8_ADR_CTRL, 32'h117);
    repeat (600) @(posedge clk_i);
    meas(0, 4 * (n + 1));
    `CHK("toggle high", 2 * (n + 1), hi);
    m = $urandom % n;
    wb_xfer(1, `TMR8_ADR_CMPB, m);
    wb_xfer(1, `TMR8_ADR_PORT, 32'ha);
    wb_xfer(1, `TMR8_ADR_CTRL, 32'h917);
    repeat (600) @(posedge clk_i);
    meas(1, n + 1);
    `CHK("pwm b high", m + 1, hi);
    stop_test;
  end
endmodule // timer8_compare_waveform_modes_tb_top
